/* File: src/standby_state_transfer_scheduler.sv */
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module standby_state_transfer_scheduler #(
   parameter logic [16:0] TOTAL_COIL = sst_pkg::TOTAL_DEFAULT,
   parameter logic [16:0] TOTAL_DISC = sst_pkg::TOTAL_DEFAULT,
   parameter logic [16:0] TOTAL_INREG = sst_pkg::TOTAL_DEFAULT,
   parameter logic [16:0] TOTAL_HOLD = sst_pkg::TOTAL_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic scanStart,
   output logic memRdReq,
   output sst_pkg::stateReq_t memReq,
   input wire logic [17:0] memRdData,
   output logic txLine,
   output logic xferBusy,
   output logic scanDone
);
   import sst_pkg::*;

   // ****************************************
   // register file
   // ****************************************
   typedef enum {S_IDLE, S_NEXT, S_WAIT, S_SEND, S_DONE} state_t;

   logic [31:0] ctrl_reg;
   logic [15:0] scans_reg;
   logic [15:0] ntLo_reg;
   logic [15:0] ntHi_reg;
   logic [16:0] cfgCnt_reg [4];
   logic [16:0] cfgExt_reg [4];
   logic [31:0] lastBits_reg;
   logic overrun_reg;
   logic wrPend_reg;
   logic [7:0] wrAddr_reg;
   logic [31:0] rdMux;
   logic addrOk;
   logic cfgErr;
   xferMode_t mode;
   state_t state_reg;
   logic [15:0] sliceIdx_reg;

   assign mode = xferMode_t'(ctrl_reg[2:1]);
   assign addrOk = hsel && hready && htrans[1];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (clkEn) begin
         wrPend_reg <= addrOk && hwrite;
         wrAddr_reg <= haddr[7:0];
         if (addrOk && !hwrite) begin
            hrdata <= rdMux;
         end
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      case (haddr[7:0])
         OFS_CTRL: rdMux = ctrl_reg;
         OFS_STATUS: rdMux = {sliceIdx_reg, 13'h0000, overrun_reg, cfgErr, xferBusy};
         OFS_SCANS: rdMux = {16'h0000, scans_reg};
         OFS_NT_LO: rdMux = {16'h0000, ntLo_reg};
         OFS_NT_HI: rdMux = {16'h0000, ntHi_reg};
         OFS_BITS: rdMux = lastBits_reg;
         default: begin
            if (haddr[7:4] == OFS_COUNT_HI) begin
               rdMux = {15'h0000, cfgCnt_reg[haddr[3:2]]};
            end else if (haddr[7:4] == OFS_EXTRA_HI) begin
               rdMux = {15'h0000, cfgExt_reg[haddr[3:2]]};
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_reg <= CTRL_RST;
         scans_reg <= SCANS_RST;
         ntLo_reg <= 16'h0000;
         ntHi_reg <= 16'h0000;
         for (int k = 0; k < 4; k++) begin
            cfgCnt_reg[k] <= 17'h00000;
            cfgExt_reg[k] <= 17'h00000;
         end
      end else if (clkEn && wrPend_reg) begin
         case (wrAddr_reg)
            OFS_CTRL: ctrl_reg <= hwdata;
            OFS_SCANS: scans_reg <= hwdata[15:0];
            OFS_NT_LO: ntLo_reg <= hwdata[15:0];
            OFS_NT_HI: ntHi_reg <= hwdata[15:0];
            default: begin
               if (wrAddr_reg[7:4] == OFS_COUNT_HI) begin
                  cfgCnt_reg[wrAddr_reg[3:2]] <= hwdata[16:0];
               end else if (wrAddr_reg[7:4] == OFS_EXTRA_HI) begin
                  cfgExt_reg[wrAddr_reg[3:2]] <= hwdata[16:0];
               end
            end
         endcase
      end
   end

   // the device cannot refuse a bad setup, so it is only reported
   always_comb begin
      cfgErr = 1'b0;
      if (mode == MODE_PERSCAN || mode == MODE_MULTISCAN) begin
         for (int k = 0; k < 4; k++) begin
            if (cfgCnt_reg[k][3:0] != 4'h0 || cfgExt_reg[k][3:0] != 4'h0) begin
               cfgErr = 1'b1;
            end
         end
         if (cfgCnt_reg[3] < GRAN) begin
            cfgErr = 1'b1;
         end
      end
   end

   // ****************************************
   // effective counts per type
   // ****************************************
   logic [16:0] totalArr [4];
   logic [16:0] defArr [4];
   logic [16:0] effCnt [4];
   logic [16:0] effSlice [4];
   logic [16:0] extAmt;
   logic [15:0] scansEff;

   assign totalArr = '{TOTAL_COIL, TOTAL_DISC, TOTAL_INREG, TOTAL_HOLD};
   assign defArr = '{DEF_COIL, DEF_DISC, DEF_INREG, DEF_HOLD};
   assign scansEff = (scans_reg == 16'h0000) ? 16'h0001 : scans_reg;

   function automatic logic [16:0] minOf(input logic [16:0] a, input logic [16:0] b);
      return (a < b) ? a : b;
   endfunction

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         effCnt[k] = 17'h00000;
         effSlice[k] = 17'h00000;
         extAmt = 17'h00000;
         case (mode)
            MODE_DEFAULT: begin
               if (k == 3) begin
                  extAmt = {defArr[k][16:4], 4'h0} + ((defArr[k][3:0] != 4'h0) ? GRAN : 17'h0);
                  effCnt[k] = minOf(extAmt, totalArr[k]);
                  extAmt = 17'h00000;
               end else begin
                  effCnt[k] = minOf(defArr[k], totalArr[k]);
               end
            end
            MODE_PERSCAN, MODE_MULTISCAN: begin
               effCnt[k] = minOf(cfgCnt_reg[k], totalArr[k]);
               if (mode == MODE_MULTISCAN) begin
                  extAmt = minOf(cfgExt_reg[k], totalArr[k] - effCnt[k]);
               end
            end
            MODE_ALL: effCnt[k] = totalArr[k];
            default: effCnt[k] = 17'h00000;
         endcase
         effSlice[k] = 17'(extAmt / {1'b0, scansEff});
      end
   end

   // ****************************************
   // scan sequencer
   // ****************************************
   logic [16:0] latCnt_reg [4];
   logic [16:0] latSlice_reg [4];
   refKind_t kind_reg;
   logic extraPhase_reg;
   logic [16:0] idx_reg;
   logic [16:0] end_reg;
   logic [31:0] bits_reg;
   logic serStart_reg;
   linkFrame_t frame_reg;
   logic serReady;
   logic [16:0] extStart;
   logic [4:0] itemBits;
   logic inSkip;

   assign extStart = latCnt_reg[kind_reg] + 17'(latSlice_reg[kind_reg] * sliceIdx_reg);
   assign inSkip = ctrl_reg[CTRL_NT_BIT] && kind_reg == KIND_HOLD
                   && idx_reg >= {1'b0, ntLo_reg} && idx_reg <= {1'b0, ntHi_reg};

   always_comb begin
      case (kind_reg)
         KIND_COIL: itemBits = BITS_COIL;
         KIND_DISC: itemBits = BITS_DISC;
         KIND_INREG: itemBits = BITS_INREG;
         default: itemBits = BITS_HOLD;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         kind_reg <= KIND_COIL;
         extraPhase_reg <= 1'b0;
         idx_reg <= 17'h00000;
         end_reg <= 17'h00000;
         bits_reg <= 32'h0000_0000;
         lastBits_reg <= 32'h0000_0000;
         sliceIdx_reg <= 16'h0000;
         memRdReq <= 1'b0;
         memReq <= '0;
         frame_reg <= '0;
         serStart_reg <= 1'b0;
         xferBusy <= 1'b0;
         scanDone <= 1'b0;
         for (int k = 0; k < 4; k++) begin
            latCnt_reg[k] <= 17'h00000;
            latSlice_reg[k] <= 17'h00000;
         end
      end else if (clkEn) begin
         memRdReq <= 1'b0;
         serStart_reg <= 1'b0;
         scanDone <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               // counts are frozen for the whole scan so a bus write cannot tear it
               if (scanStart && ctrl_reg[CTRL_EN_BIT]) begin
                  latCnt_reg <= effCnt;
                  latSlice_reg <= effSlice;
                  kind_reg <= KIND_COIL;
                  extraPhase_reg <= 1'b0;
                  idx_reg <= 17'h00000;
                  end_reg <= effCnt[0];
                  bits_reg <= 32'h0000_0000;
                  xferBusy <= 1'b1;
                  state_reg <= S_NEXT;
               end
            end
            S_NEXT: begin
               if (idx_reg >= end_reg) begin
                  if (!extraPhase_reg) begin
                     extraPhase_reg <= 1'b1;
                     idx_reg <= extStart;
                     end_reg <= extStart + latSlice_reg[kind_reg];
                  end else if (kind_reg == KIND_HOLD) begin
                     state_reg <= S_DONE;
                  end else begin
                     kind_reg <= refKind_t'(2'(kind_reg + 1));
                     extraPhase_reg <= 1'b0;
                     idx_reg <= 17'h00000;
                     end_reg <= latCnt_reg[2'(kind_reg + 1)];
                  end
               end else if (inSkip) begin
                  idx_reg <= idx_reg + 17'h00001;
               end else begin
                  memRdReq <= 1'b1;
                  memReq <= '{kind: kind_reg, index: idx_reg[15:0]};
                  state_reg <= S_WAIT;
               end
            end
            S_WAIT: begin
               frame_reg <= '{kind: kind_reg, data: memRdData};
               state_reg <= S_SEND;
            end
            S_SEND: begin
               if (serReady) begin
                  serStart_reg <= 1'b1;
                  bits_reg <= bits_reg + {27'h0, itemBits};
                  idx_reg <= idx_reg + 17'h00001;
                  state_reg <= S_NEXT;
               end
            end
            S_DONE: begin
               lastBits_reg <= bits_reg;
               sliceIdx_reg <= (sliceIdx_reg + 16'h0001 >= scansEff) ? 16'h0000
                               : sliceIdx_reg + 16'h0001;
               xferBusy <= 1'b0;
               scanDone <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // the controller is never held; a scan start during a transfer is dropped and flagged
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         overrun_reg <= 1'b0;
      end else if (clkEn) begin
         if (scanStart && state_reg != S_IDLE) begin
            overrun_reg <= 1'b1;
         end else if (wrPend_reg && wrAddr_reg == OFS_STATUS && hwdata[ST_OVR_BIT]) begin
            overrun_reg <= 1'b0;
         end
      end
   end

   link_serializer #(.WIDTH(FRAME_W), .CYC(BIT_CYC)) link_serializer_inst (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .start(serStart_reg),
      .frame(frame_reg),
      .ready(serReady),
      .txLine(txLine)
   );

   // ****************************************
   // checks
   // ****************************************
   logic [1:0] maxKind_reg;
   always_ff @(posedge sys_clk) begin
      if (!rst_n || scanDone) begin
         maxKind_reg <= 2'h0;
      end else if (memRdReq) begin
         maxKind_reg <= memReq.kind;
      end
   end

   property p_order;
      @(posedge sys_clk) disable iff (!rst_n) memRdReq |-> memReq.kind >= maxKind_reg;
   endproperty
   a_order: assert property (p_order) else $error("reference type order broken");

   property p_deflim;
      @(posedge sys_clk) disable iff (!rst_n)
      memRdReq && mode == MODE_DEFAULT && memReq.kind != KIND_HOLD
      |-> {1'b0, memReq.index} < defArr[memReq.kind];
   endproperty
   a_deflim: assert property (p_deflim) else $error("default limit exceeded");

   property p_definreg;
      @(posedge sys_clk) disable iff (!rst_n)
      memRdReq && mode == MODE_DEFAULT && memReq.kind == KIND_INREG
      |-> {1'b0, memReq.index} < DEF_INREG;
   endproperty
   a_definreg: assert property (p_definreg) else $error("input register budget exceeded");

   property p_round;
      @(posedge sys_clk) disable iff (!rst_n)
      xferBusy && mode == MODE_DEFAULT
      |-> latCnt_reg[3][3:0] == 4'h0 || latCnt_reg[3] == TOTAL_HOLD;
   endproperty
   a_round: assert property (p_round) else $error("holding count not rounded");

   property p_limit;
      @(posedge sys_clk) disable iff (!rst_n)
      memRdReq |-> {1'b0, memReq.index} < totalArr[memReq.kind];
   endproperty
   a_limit: assert property (p_limit) else $error("reference beyond memory");

   property p_skip;
      @(posedge sys_clk) disable iff (!rst_n)
      memRdReq && ctrl_reg[CTRL_NT_BIT] && memReq.kind == KIND_HOLD
      |-> memReq.index < ntLo_reg || memReq.index > ntHi_reg;
   endproperty
   a_skip: assert property (p_skip) else $error("non-transfer register copied");

   property p_send;
      @(posedge sys_clk) disable iff (!rst_n)
      serStart_reg |-> bits_reg == $past(bits_reg) + {27'h0, $past(itemBits)};
   endproperty
   a_send: assert property (p_send) else $error("size accounting wrong");

   property p_slice;
      @(posedge sys_clk) disable iff (!rst_n) scanDone |-> sliceIdx_reg < scansEff;
   endproperty
   a_slice: assert property (p_slice) else $error("slice index out of range");

   property p_ovr;
      @(posedge sys_clk) disable iff (!rst_n)
      clkEn && scanStart && xferBusy |=> overrun_reg;
   endproperty
   a_ovr: assert property (p_ovr) else $error("dropped scan not flagged");

   c_scan: cover property (@(posedge sys_clk) disable iff (!rst_n) scanDone);
   c_multi: cover property (@(posedge sys_clk) disable iff (!rst_n)
      scanDone && mode == MODE_MULTISCAN && sliceIdx_reg == 16'h0000);
   c_skip: cover property (@(posedge sys_clk) disable iff (!rst_n) state_reg == S_NEXT && inSkip);

endmodule

/* File: src/sst_pkg.sv */
package sst_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned LINK_BAUD = 10_000_000;
   localparam int unsigned BIT_CYC = CLK_HZ / LINK_BAUD;

   // ****************************************
   // widths and sizes
   // ****************************************
   localparam int CNT_W = 17;
   localparam int DATA_W = 18;
   localparam int FRAME_W = 20;
   localparam logic [16:0] GRAN = 17'h00010;
   localparam logic [16:0] DEF_COIL = 17'h02000;
   localparam logic [16:0] DEF_DISC = 17'h02000;
   localparam logic [16:0] DEF_INREG = 17'h00400;
   localparam logic [16:0] DEF_HOLD = 17'h02400;
   localparam logic [16:0] TOTAL_DEFAULT = 17'h10000;
   localparam logic [4:0] BITS_COIL = 5'h03;
   localparam logic [4:0] BITS_DISC = 5'h03;
   localparam logic [4:0] BITS_INREG = 5'h10;
   localparam logic [4:0] BITS_HOLD = 5'h12;

   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SCANS = 8'h08;
   localparam logic [7:0] OFS_NT_LO = 8'h0C;
   localparam logic [7:0] OFS_NT_HI = 8'h10;
   localparam logic [7:0] OFS_BITS = 8'h14;
   localparam logic [3:0] OFS_COUNT_HI = 4'h2;
   localparam logic [3:0] OFS_EXTRA_HI = 4'h3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] SCANS_RST = 16'h0001;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_NT_BIT = 3;
   localparam int ST_OVR_BIT = 2;

   typedef enum logic [1:0] {KIND_COIL, KIND_DISC, KIND_INREG, KIND_HOLD} refKind_t;
   typedef enum logic [1:0] {MODE_DEFAULT, MODE_PERSCAN, MODE_MULTISCAN, MODE_ALL} xferMode_t;

   typedef struct packed {
      refKind_t kind;
      logic [15:0] index;
   } stateReq_t;

   typedef struct packed {
      refKind_t kind;
      logic [17:0] data;
   } linkFrame_t;

endpackage

/* File: src/link_serializer.sv */
`timescale 1ns/100ps
module link_serializer #(
   parameter int WIDTH = sst_pkg::FRAME_W,
   parameter int CYC = sst_pkg::BIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic start,
   input wire logic [WIDTH-1:0] frame,
   output logic ready,
   output logic txLine
);
   import sst_pkg::*;

   // start bit, WIDTH data bits lsb first, stop bit; line idles high
   logic [WIDTH+1:0] shift_reg;
   logic [5:0] bitsLeft_reg;
   logic [7:0] cyc_reg;

   assign ready = (bitsLeft_reg == 6'h00);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shift_reg <= '1;
         bitsLeft_reg <= 6'h00;
         cyc_reg <= 8'h00;
         txLine <= 1'b1;
      end else if (clkEn) begin
         if (ready) begin
            txLine <= 1'b1;
            if (start) begin
               shift_reg <= {1'b1, frame, 1'b0};
               bitsLeft_reg <= 6'(WIDTH + 2);
               cyc_reg <= 8'h00;
            end
         end else begin
            txLine <= shift_reg[0];
            if (cyc_reg == 8'(CYC - 1)) begin
               cyc_reg <= 8'h00;
               shift_reg <= {1'b1, shift_reg[WIDTH+1:1]};
               bitsLeft_reg <= bitsLeft_reg - 6'h01;
            end else begin
               cyc_reg <= cyc_reg + 8'h01;
            end
         end
      end
   end

   property p_baud;
      @(posedge sys_clk) disable iff (!rst_n)
      !ready |-> cyc_reg < 8'(CYC);
   endproperty
   a_baud: assert property (p_baud) else $error("bit period counter overran");

endmodule

/* File: verification/standby_partner.sv */
`timescale 1ns/100ps
module standby_partner (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic memRdReq,
   input wire sst_pkg::stateReq_t memReq,
   output logic [17:0] memRdData,
   input wire logic txLine,
   output int frameCount,
   output logic [19:0] lastFrame
);
   logic [1:0] st;
   logic [3:0] cnt;
   logic [4:0] bitN;
   logic [19:0] sh;
   // ********
   // state memory
   // ********
   // data stands while the request does: it is taken at the edge that ends memRdReq
   // outside a request the word is inverted, so a late sample shows up as a mismatch
   always_comb begin
      if (memRdReq) begin
         memRdData = {memReq.kind, memReq.index};
      end else begin
         memRdData = ~{memReq.kind, memReq.index};
      end
   end
   // ********
   // link receiver
   // ********
   // samples near mid-bit, ten cycles apart, LSB first
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= 2'h0;
         frameCount <= 0;
      end else if (st == 2'h0 && !txLine) begin
         st <= 2'h1;
         cnt <= 4'h5;
         bitN <= 5'h00;
      end else if (st == 2'h1) begin
         if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else begin
            cnt <= 4'h9;
            bitN <= bitN + 5'h01;
            if (bitN != 5'h00) begin
               sh <= {txLine, sh[19:1]};
            end
            if (bitN == 5'h14) begin
               st <= 2'h2;
               lastFrame <= {txLine, sh[19:1]};
               frameCount <= frameCount + 1;
            end
         end
      end else if (st == 2'h2 && txLine) begin
         st <= 2'h0;
      end
   end
endmodule

/* File: verification/standby_state_transfer_scheduler_tb_top.sv */
`timescale 1ns/100ps
module standby_state_transfer_scheduler_tb_top;
   import sst_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic scanStart = 1'b0;
   logic clkEn = 1'b1;
   logic hsel = 1'b1;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, memRdReq, txLine, xferBusy, scanDone;
   stateReq_t memReq;
   logic [17:0] memRdData;
   int frameCount, fBase;
   logic [19:0] lastFrame;
   int bad_count = 0;
   int checks_done = 0;
   stateReq_t expQ[$];
   stateReq_t gotQ[$];

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   standby_state_transfer_scheduler #(.TOTAL_COIL(17'h00020), .TOTAL_DISC(17'h00010),
      .TOTAL_INREG(17'h00010), .TOTAL_HOLD(17'h00028)) standby_state_transfer_scheduler_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scanStart(scanStart),
      .memRdReq(memRdReq), .memReq(memReq), .memRdData(memRdData), .txLine(txLine),
      .xferBusy(xferBusy), .scanDone(scanDone));

   standby_partner standby_partner_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .memRdReq(memRdReq), .memReq(memReq), .memRdData(memRdData), .txLine(txLine),
      .frameCount(frameCount), .lastFrame(lastFrame));

   // ********
   // shared tasks
   // ********
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task wait_rdy;
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && n < 100) begin
         n++;
         @(posedge sys_clk);
      end
      if (n >= 100) begin
         bad_count++;
         close_out;
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask

   task start_scan;
      fBase = frameCount;
      scanStart <= 1'b1;
      @(posedge sys_clk);
      scanStart <= 1'b0;
   endtask

   task expr(input refKind_t k, input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         expQ.push_back('{k, 16'(i)});
      end
   endtask

   task expect_full;
      expQ.delete();
      expr(KIND_COIL, 0, 31);
      expr(KIND_DISC, 0, 15);
      expr(KIND_INREG, 0, 15);
      expr(KIND_HOLD, 0, 39);
   endtask

   task collect(input bit cmp);
      int n;
      gotQ.delete();
      n = 0;
      do begin
         @(negedge sys_clk);
         if (memRdReq === 1'b1) begin
            gotQ.push_back(memReq);
         end
         n++;
      end while (scanDone !== 1'b1 && n < 40000);
      if (n >= 40000) begin
         bad_count++;
         close_out;
      end
      // the last frame is still on the link when scanDone pulses
      repeat (240) @(posedge sys_clk);
      if (cmp) begin
         check(gotQ.size(), expQ.size());
         foreach (expQ[i]) begin
            check({14'h0, gotQ[i]}, {14'h0, expQ[i]});
         end
         check(frameCount - fBase, expQ.size());
         check({30'h0, lastFrame[19:18]}, {30'h0, expQ[$].kind});
         check({29'h0, lastFrame[2:0]}, {29'h0, expQ[$].index[2:0]});
      end
   endtask

   // ********
   // scenarios
   // ********
   task t_reset;
      bus(1'b0, OFS_CTRL, 32'h0);
      check(rd, CTRL_RST);
      bus(1'b0, OFS_SCANS, 32'h0);
      check(rd, {16'h0000, SCANS_RST});
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      start_scan;
      @(posedge sys_clk);
      check({31'h0, xferBusy}, 32'h0);
      check({29'h0, hresp, hreadyout, txLine}, 32'h3);
      // a write without select must be ignored
      hsel <= 1'b0;
      bus(1'b1, OFS_SCANS, 32'h00000005);
      hsel <= 1'b1;
      bus(1'b0, OFS_SCANS, 32'h0);
      check(rd, {16'h0000, SCANS_RST});
      // a scan start while the clock enable is low must not be taken
      bus(1'b1, OFS_CTRL, 32'h00000001);
      clkEn <= 1'b0;
      start_scan;
      clkEn <= 1'b1;
      @(posedge sys_clk);
      check({31'h0, xferBusy}, 32'h0);
      $display("test reset done");
   endtask

   task t_default;
      bus(1'b1, OFS_CTRL, 32'h00000001);
      expect_full;
      start_scan;
      collect(1'b1);
      bus(1'b0, OFS_BITS, 32'h0);
      check(rd, 32'h00000460);
      $display("test default done");
   endtask

   task t_all;
      bus(1'b1, OFS_CTRL, 32'h00000007);
      expect_full;
      start_scan;
      collect(1'b1);
      $display("test all done");
   endtask

   task t_overrun;
      bus(1'b1, 8'h2C, 32'h00000010);
      bus(1'b1, OFS_CTRL, 32'h00000003);
      start_scan;
      @(posedge sys_clk);
      start_scan;
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rd & 32'h5, 32'h5);
      bus(1'b1, OFS_STATUS, 32'h00000004);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rd & 32'h4, 32'h0);
      collect(1'b0);
      $display("test overrun done");
   endtask

   task t_skip;
      bus(1'b1, 8'h2C, 32'h00000020);
      bus(1'b1, OFS_NT_LO, 32'h00000004);
      bus(1'b1, OFS_NT_HI, 32'h00000007);
      bus(1'b1, OFS_CTRL, 32'h0000000B);
      expQ.delete();
      expr(KIND_HOLD, 0, 3);
      expr(KIND_HOLD, 8, 31);
      start_scan;
      collect(1'b1);
      $display("test skip done");
   endtask

   task t_multi;
      bus(1'b1, 8'h20, 32'h00000010);
      bus(1'b1, 8'h30, 32'h00000010);
      bus(1'b1, 8'h2C, 32'h00000010);
      bus(1'b1, OFS_SCANS, 32'h00000002);
      bus(1'b1, OFS_CTRL, 32'h00000005);
      for (int s = 0; s < 2; s++) begin
         expQ.delete();
         expr(KIND_COIL, 0, 15);
         expr(KIND_COIL, 16 + 8 * s, 23 + 8 * s);
         expr(KIND_HOLD, 0, 15);
         start_scan;
         collect(1'b1);
      end
      bus(1'b0, OFS_BITS, 32'h0);
      check(rd, 32'h00000168);
      $display("test multi done");
   endtask

   initial begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_default;
      t_overrun;
      t_skip;
      t_multi;
      t_all;
      close_out;
   end
endmodule
